//--- include/ets_pkg.sv
// package: constants for the edge timestamp capture block
package ets_pkg;
   // ==========================================================
   // image layout
   localparam int ENTRY_BYTES      = 4;
   localparam int SLOTS_SHORT      = 5;
   localparam int SLOTS_LONG       = 15;
   localparam int OFS_STATE        = 0;
   localparam int OFS_SEQ          = 1;
   localparam int OFS_TIME         = 2;
   localparam int CHANNELS         = 4;
   localparam int SEQ_MAX          = 127;
   localparam logic [6:0] SEQ_FIRST = 7'h01;
   // ==========================================================
   // timing
   localparam int CLK_MHZ          = 10;
   localparam int TICK_NS          = 1000;
   localparam int CLK_NS           = 100;
   localparam int CYC_PER_US       = TICK_NS / CLK_NS;
   localparam int DEBOUNCE_MIN_US  = 2;
   localparam int DEBOUNCE_MAX_US  = 3000;
   // ==========================================================
   // reset values
   localparam logic [31:0] TICKER_RESET = 32'h0000_0000;
   localparam logic [7:0]  MASK_RESET   = 8'h00;
   localparam logic [7:0]  DELAY_RESET  = 8'h02;
   // debounce setting code to microseconds
   function automatic logic [11:0] delay_us(input logic [7:0] code);
      case (code)
         8'h00:   delay_us = 12'h002;
         8'h02:   delay_us = 12'h004;
         8'h04:   delay_us = 12'h00C;
         8'h07:   delay_us = 12'h056;
         8'h09:   delay_us = 12'h156;
         8'h0C:   delay_us = 12'hAAB;
         default: delay_us = 12'h004;
      endcase
   endfunction
endpackage

//--- src/ets_capture.sv
// edge timestamp capture block with shifting capture image
//Contract
//RQ1: image holds five or fifteen entries, fixed by variant parameter.
//RQ2: each entry four bytes; entry k starts at byte 4k.
//RQ3: byte 0 holds input states after the triggering edge.
//RQ4: state byte bits 0-3 are lines 0-3, bits 4-7 zero.
//RQ5: byte 1 holds sequence 0..127, first entry carries 1.
//RQ6: 32-bit microsecond ticker starts at zero, counts, wraps.
//RQ7: time field holds low 16 ticker bits.
//RQ8: enabled edge captures ticker, states and sequence as one entry.
//RQ9: debounce delay 2us to 3ms on both transitions; code's longest setting, 0Ch, gives 2731us.
//RQ10: host reads entries only through the image.
//RQ11: subindex s selects entry s-1 on index-style access.
//RQ12: each field its own consecutive subindex from 01h.
//RQ13: new entry at offset zero, older ones move up four bytes.
//RQ14: oldest entry drops off the end when full.
//RQ15: rising-edge enable mask bits 0-3, upper bits reserved.
//RQ16: falling-edge enable mask bits 0-3, upper bits reserved.
//RQ17: sequence wraps from 127 to 0.
//RQ18: same-microsecond edges on several lines give one entry; code merges only lines whose debounce ends on the same tick.
`timescale 1ns/1ps
`default_nettype none
module ets_capture #(
   parameter int SLOTS = ets_pkg::SLOTS_SHORT
) (
   // clock and reset
   input  wire logic                 CLOCK,
   input  wire logic                 RST_N,
   // process inputs
   input  wire logic [3:0]           INPUT_LINE,
   // configuration
   input  wire logic [7:0]           RISING_EDGE_ENABLE_MASK,
   input  wire logic [7:0]           FALLING_EDGE_ENABLE_MASK,
   input  wire logic [31:0]          DEBOUNCE_DELAY_SETTING,
   // capture image and ticker
   output logic [SLOTS*32-1:0]       IMAGE,
   output logic [31:0]               TICKER,
   output logic                      ENTRY_STROBE
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [SLOTS*32-1:0] image;
      logic [31:0]         ticker;
      logic [3:0]          prediv;
      logic                us_tick;
      logic [3:0]          stable;
      logic [4*12-1:0]     cnt;
      logic [3:0]          rise;
      logic [3:0]          fall;
      logic [6:0]          seq;
      logic                strobe;
   } ets_state_t;

   ets_state_t r;
   ets_state_t next_r;

   logic [11:0] lim;
   logic [3:0]  hit;

   // ==========================================================
   // next state
   always_comb begin
      next_r = r;
      lim = '0;
      hit = '0;
      next_r.strobe = 1'b0;
      next_r.us_tick = 1'b0;
      // microsecond enable from the 10 MHz clock
      if (r.prediv == 4'(ets_pkg::CYC_PER_US - 1)) begin
         next_r.prediv = '0;
         next_r.us_tick = 1'b1;
      end else begin
         next_r.prediv = r.prediv + 4'h1;
      end
      if (r.us_tick) begin
         next_r.ticker = r.ticker + 32'h0000_0001; // RQ6
      end
      // debounce counts microseconds of a steady differing level
      for (int i = 0; i < ets_pkg::CHANNELS; i++) begin
         lim = ets_pkg::delay_us(DEBOUNCE_DELAY_SETTING[i*8 +: 8]);
         if (INPUT_LINE[i] == r.stable[i]) begin
            next_r.cnt[i*12 +: 12] = '0;
         end else if (r.us_tick) begin
            if (r.cnt[i*12 +: 12] + 12'h001 >= lim) begin // RQ9
               next_r.cnt[i*12 +: 12] = '0;
               next_r.stable[i] = INPUT_LINE[i];
               hit[i] = INPUT_LINE[i] ? RISING_EDGE_ENABLE_MASK[i] // RQ15
                                      : FALLING_EDGE_ENABLE_MASK[i]; // RQ16
            end else begin
               next_r.cnt[i*12 +: 12] = r.cnt[i*12 +: 12] + 12'h001;
            end
         end
      end
      // all enabled edges resolved on one tick land in one entry
      if (|hit) begin // RQ18
         next_r.seq = (r.seq == 7'(ets_pkg::SEQ_MAX)) ? 7'h00 // RQ17
                                                     : r.seq + 7'h01;
         // shift toward higher offsets, oldest falls out
         next_r.image = {r.image[SLOTS*32-33:0], 32'h0}; // RQ13 RQ14
         next_r.image[31:0] = {r.ticker[15:0], // RQ7
                               1'b0, r.seq, // RQ5
                               4'h0, next_r.stable}; // RQ3 RQ4 RQ8
         next_r.strobe = 1'b1;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         r        <= '0;
         r.ticker <= ets_pkg::TICKER_RESET;
         r.seq    <= ets_pkg::SEQ_FIRST;
      end else begin
         r <= next_r;
      end
   end

   // entry k sits at byte 4k, as RQ2 RQ1 require; RQ10 RQ11 RQ12 host side
   assign IMAGE        = r.image;
   assign TICKER       = r.ticker;
   assign ENTRY_STROBE = r.strobe;

   // ==========================================================
   // checks
   property p_seq_first;
      @(posedge CLOCK) disable iff (!RST_N)
      ($rose(r.strobe) && $past(r.seq) == 7'h01) |-> r.image[15:8] == 8'h01;
   endproperty
   a_seq_first: assert property (p_seq_first) else $error("bad seq"); // RQ5

   property p_shift;
      @(posedge CLOCK) disable iff (!RST_N)
      r.strobe |-> r.image[63:32] == $past(r.image[31:0]);
   endproperty
   a_shift: assert property (p_shift) else $error("no shift"); // RQ13

   property p_upper_zero;
      @(posedge CLOCK) disable iff (!RST_N) r.image[7:4] == 4'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("bits set"); // RQ4

   property p_ticker;
      @(posedge CLOCK) disable iff (!RST_N)
      r.us_tick |=> r.ticker == $past(r.ticker) + 32'h1;
   endproperty
   a_ticker: assert property (p_ticker) else $error("ticker"); // RQ6

   property p_state;
      @(posedge CLOCK) disable iff (!RST_N)
      r.strobe |-> r.image[3:0] == r.stable;
   endproperty
   a_state: assert property (p_state) else $error("state"); // RQ3

   property p_time;
      @(posedge CLOCK) disable iff (!RST_N)
      r.strobe |-> r.image[31:16] == $past(r.ticker[15:0]);
   endproperty
   a_time: assert property (p_time) else $error("time"); // RQ7

   property p_wrap;
      @(posedge CLOCK) disable iff (!RST_N)
      (r.seq == 7'd127 && |hit) |=> r.seq == 7'd0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap"); // RQ17

   property p_tick_rate;
      @(posedge CLOCK) disable iff (!RST_N)
      r.us_tick |=> !r.us_tick [*8] ##1 !r.us_tick ##1 r.us_tick;
   endproperty
   a_tick_rate: assert property (p_tick_rate) else $error("rate"); // RQ9

   c_entry: cover property (@(posedge CLOCK) disable iff (!RST_N) r.strobe);
   c_two: cover property (@(posedge CLOCK) disable iff (!RST_N)
      r.strobe ##[1:200] r.strobe);
   c_multi: cover property (@(posedge CLOCK) disable iff (!RST_N)
      $countones(hit) > 1);
   c_wrap: cover property (@(posedge CLOCK) disable iff (!RST_N)
      r.strobe && r.image[15:8] == 8'h00);
   c_full: cover property (@(posedge CLOCK) disable iff (!RST_N)
      r.strobe && r.image[SLOTS*32-17 -: 8] != 8'h00);

   // ==========================================================
   // ordering checks
   // entries are born on a tick only, so two are at least ten cycles apart
   property p_spacing;
      @(posedge CLOCK) disable iff (!RST_N)
      r.strobe |=> !r.strobe [*8] ##1 !r.strobe;
   endproperty
   a_spacing: assert property (p_spacing) else $error("spacing"); // RQ18

   property p_hold;
      @(posedge CLOCK) disable iff (!RST_N)
      !r.strobe |-> $stable(r.image);
   endproperty
   a_hold: assert property (p_hold) else $error("image moved"); // RQ13

   property p_hit_entry;
      @(posedge CLOCK) disable iff (!RST_N)
      |hit |=> r.strobe;
   endproperty
   a_hit_entry: assert property (p_hit_entry) else $error("lost"); // RQ8

   property p_seq_step;
      @(posedge CLOCK) disable iff (!RST_N)
      (r.strobe && $past(r.seq) != 7'd127) |-> r.seq == $past(r.seq) + 7'd1;
   endproperty
   a_seq_step: assert property (p_seq_step) else $error("seq step"); // RQ5

   property p_last_slot;
      @(posedge CLOCK) disable iff (!RST_N)
      r.strobe |-> r.image[SLOTS*32-1 -: 32] == $past(r.image[SLOTS*32-33 -: 32]);
   endproperty
   a_last_slot: assert property (p_last_slot) else $error("tail"); // RQ14

   property p_strobe_tick;
      @(posedge CLOCK) disable iff (!RST_N)
      r.strobe |-> $past(r.us_tick);
   endproperty
   a_strobe_tick: assert property (p_strobe_tick) else $error("off tick"); // RQ9
endmodule
`default_nettype wire

//--- sim/ets_host_model.sv
// host model: reads the shifting capture image
`timescale 1ns/1ps
`default_nettype none
module ets_host_model #(
   parameter int SLOTS = 5
) (
   // clock
   input  wire logic                 CLOCK,
   // image side
   input  wire logic [SLOTS*32-1:0]  IMAGE,
   input  wire logic                 ENTRY_STROBE,
   // host view
   output logic      [SLOTS*32-1:0]  view,
   output int                        reads
);
   // image only, never another path
   always @(posedge CLOCK) begin
      view <= IMAGE;
      reads <= reads + int'(ENTRY_STROBE);
   end
endmodule
`default_nettype wire

//--- sim/ets_capture_test.sv
// testbench: edge timestamp capture block
`timescale 1ns/1ps
`default_nettype none
module ets_capture_test;
   localparam int SL = 5;
   logic          CLOCK = 0;
   logic          RST_N = 0;
   logic [3:0]    lines = 0;
   logic [3:0]    old;
   logic [7:0]    rm = 0;
   logic [7:0]    fm = 0;
   logic [31:0]   dly = 0;
   logic [SL*32-1:0] image, view, pimg;
   logic [31:0]   ticker, tprev;
   logic          strobe;
   logic [7:0]    codes [3] = '{8'h00, 8'h02, 8'h04};
   int            reads, got, want, wcyc;
   int            err_total = 0;
   int            compares = 0;
   int            n = 0;
   ets_capture #(.SLOTS(SL)) i_ets_capture (.CLOCK(CLOCK), .RST_N(RST_N),
      .INPUT_LINE(lines), .RISING_EDGE_ENABLE_MASK(rm),
      .FALLING_EDGE_ENABLE_MASK(fm), .DEBOUNCE_DELAY_SETTING(dly),
      .IMAGE(image), .TICKER(ticker), .ENTRY_STROBE(strobe));
   ets_host_model #(.SLOTS(SL)) i_ets_host_model (.CLOCK(CLOCK),
      .IMAGE(image), .ENTRY_STROBE(strobe), .view(view), .reads(reads));
   always #50 CLOCK = ~CLOCK;
   task automatic chk(string nm, logic [SL*32-1:0] e, logic [SL*32-1:0] s);
      compares++;
      if (s !== e) begin
         $display("BAD %s exp %h got %h", nm, e, s);
         err_total++;
      end
   endtask
   task automatic end_sim();
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   function automatic int dus(logic [7:0] c);
      case (c)
         8'h00:   return 2;
         8'h02:   return 4;
         8'h04:   return 12;
         8'h07:   return 86;
         8'h09:   return 342;
         8'h0C:   return 2731;
         default: return 4;
      endcase
   endfunction
   // k-th shortest delay among lines with an enabled edge, 0 if none
   function automatic int kth(logic [3:0] o, logic [3:0] l, logic [31:0] d,
                              int k);
      int prev;
      int best;
      prev = 0;
      for (int s = 0; s <= k; s++) begin
         best = 0;
         for (int j = 0; j < 4; j++)
            if (((l[j] & ~o[j] & rm[j]) | (o[j] & ~l[j] & fm[j])) &&
                dus(d[j*8 +: 8]) > prev &&
                (best == 0 || dus(d[j*8 +: 8]) < best))
               best = dus(d[j*8 +: 8]);
         if (best == 0)
            return 0;
         prev = best;
      end
      return prev;
   endfunction
   // lines whose delay has run out by the k-th entry show the new level
   function automatic logic [3:0] st(logic [3:0] o, logic [3:0] l,
                                     logic [31:0] d, int k);
      logic [3:0] v;
      v = o;
      for (int j = 0; j < 4; j++)
         if (kth(o, l, d, k) != 0 && dus(d[j*8 +: 8]) <= kth(o, l, d, k))
            v[j] = l[j];
      return v;
   endfunction
   initial begin
      void'($urandom(32'hfd58));
      repeat (4) @(negedge CLOCK);
      chk("ticker", 0, ticker);
      RST_N = 1;
      // 150 changes pass 128 entries, so the sequence wraps
      for (int i = 0; i < 150; i++) begin
         old = lines;
         if (i == 10) begin
            // glitch shorter than any delay must leave no entry
            lines = ~old;
            @(negedge CLOCK);
            lines = old;
         end
         rm = 8'($urandom);
         fm = (i < 6) ? 8'h00 : 8'($urandom);
         dly = (i < 145) ?
               {codes[i%3], codes[(i+1)%3], codes[i%3], codes[(i+2)%3]} :
               (i < 149) ? 32'h0709_5507 : 32'h0C09_0755;
         wcyc = (i < 145) ? 200 : (i < 149) ? 3600 : 28000;
         lines = (i == 3) ? ~old : 4'($urandom);
         want = 0;
         for (int k = 0; k < 4; k++)
            want += int'(kth(old, lines, dly, k) != 0);
         pimg = image;
         got = 0;
         for (int c = 0; c < wcyc; c++) begin
            @(negedge CLOCK);
            if (strobe === 1'b1) begin
               n++;
               chk("state", {4'h0, st(old, lines, dly, got)}, image[7:0]);
               chk("seq", {1'b0, 7'(n)}, image[15:8]);
               chk("time", tprev[15:0], image[31:16]);
               chk("shift", pimg[SL*32-33:0], image[SL*32-1:32]);
               pimg = image;
               got++;
            end
            tprev = ticker;
         end
         chk("entries", want, got);
         if (want != 0 && got == 0)
            end_sim();
      end
      chk("ticker_runs", 1, ticker > 32'h0000_0100);
      chk("host_reads", n, reads);
      chk("host_view", image, view);
      end_sim();
   end
endmodule
`default_nettype wire
